// ==== common/rx_line_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the receive line block.
`ifndef RX_LINE_DEFS_SVH
`define RX_LINE_DEFS_SVH
`define RL_OFS_CFG       8'h70
`define RL_OFS_THR       8'h71
`define RL_OFS_DETECT_PERIOD   8'h72
`define RL_OFS_CLEAR_PERIOD   8'h73
`define RL_OFS_RAM_ADDR  8'h74
`define RL_OFS_RNW       8'h75
`define RL_OFS_LOOP      8'h76
`define RL_OFS_EQ_CFG    8'h77
`define RL_OFS_DATA3     8'h78
`define RL_OFS_DATA2     8'h79
`define RL_OFS_DATA1     8'h7A
`define RL_OFS_DATA0     8'h7B
`define RL_BIT_CHG       7
`define RL_BIT_STATE     6
`define RL_BIT_IRQ_EN    5
`define RL_BIT_SQUELCH   4
`define RL_BIT_QTEST     3
`define RL_BIT_SETTLED   2
`define RL_BIT_RNW       7
`define RL_BIT_EQ_RUN    3
`define RL_CLEAR_THRESHOLD_CODE_LSB   4
`define RL_CFG_RW_MASK   8'h39
`define RL_EQ_CFG_MASK   8'hDF
`define RL_RST_CFG       8'h01
`define RL_RST_THR       8'h00
`define RL_RST_PER       8'h01
`define RL_RST_RAM_ADDR  8'h00
`define RL_RST_RNW       1'b1
`define RL_RST_EQ_CFG    8'h03
`define RL_RST_LOOP      6'h00
`define RL_THR_BASE_DB   5'h08
`define RL_THR_TOP_DB    5'h0C
`define RL_THR_TOP_CODE  3'h4
`define RL_PER_SHIFT     4
`define RL_SETTLE_STEPS  6'h08
`define RL_SETTLE_COUNT  64
`endif

// ==== common/rx_line_pkg.sv ====
// Types shared by the receive line control block and its coefficient RAM.
package rx_line_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ram_req_s;
  typedef enum logic [1:0] {IND_IDLE, IND_ACCESS, IND_CAPTURE} ind_state_e;
endpackage

// ==== design/eq_coeff_ram.sv ====
// Equalization coefficient RAM with an indirect software port and a loop read port.
`timescale 1ns/1ps
module eq_coeff_ram import rx_line_pkg::*; #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 32,
  parameter int LOC_W = 6
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic             i_req_valid,
  input  wire ram_req_s         i_req,
  input  wire logic [LOC_W-1:0] i_loc,
  output logic      [WIDTH-1:0] o_rdata,
  output logic      [WIDTH-1:0] o_coeff
);
  generate
    if (DEPTH != 256 || WIDTH != 32 || LOC_W > 8) begin : g_bad
      $error("eq_coeff_ram parameters not supported");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;
  logic [WIDTH-1:0] coeff_reg;
  logic [WIDTH-1:0] coeff_next;

  always_comb begin
    rdata_next = rdata_reg;
    coeff_next = mem[8'(i_loc)];
    if (i_req_valid && !i_req.we) begin
      rdata_next = mem[i_req.addr];
    end
  end

  // The array has no reset; software initialises it before the equalizer runs.
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && i_req_valid && i_req.we) begin
      mem[i_req.addr] <= i_req.wdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_reg <= '0;
      coeff_reg <= '0;
    end else if (i_clk_en) begin
      rdata_reg <= rdata_next;
      coeff_reg <= coeff_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_coeff = coeff_reg;
endmodule

// ==== design/rx_line_loss_monitor_eq_ctrl.sv ====
// Receive line loss-of-signal monitor, squelch, test control and equalizer control registers.
`timescale 1ns/1ps
`include "rx_line_defs.svh"
module rx_line_loss_monitor_eq_ctrl import rx_line_pkg::*; #(
  parameter int SETTLE_PERIODS = `RL_SETTLE_COUNT
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_irq_n,
  input  wire logic       i_pulse_tick,
  input  wire logic [4:0] i_cable_loss_db,
  input  wire logic       i_sample_tick,
  input  wire logic       i_eq_up,
  input  wire logic       i_eq_down,
  input  wire logic       i_global_quiescent_test,
  input  wire logic       i_rx_data,
  output logic            o_rx_data,
  output logic            o_analog_force_low,
  output logic            o_loss_state,
  output logic            o_equalizer_run,
  output logic     [31:0] o_eq_coeff
);
  localparam int SW = $clog2(SETTLE_PERIODS + 1);

  generate
    if (SETTLE_PERIODS < 1) begin : g_bad
      $error("SETTLE_PERIODS must be at least one");
    end
  endgenerate

  function automatic logic [4:0] thr_db(input logic [2:0] code);
    if (code >= `RL_THR_TOP_CODE) begin
      thr_db = `RL_THR_TOP_DB;
    end else begin
      thr_db = `RL_THR_BASE_DB + {2'b00, code};
    end
  endfunction

  function automatic logic [12:0] span(input byte_t per);
    span = {1'b0, per, 4'h0};
  endfunction

  logic wr_seen_reg;
  logic wr_seen_next;
  logic rd_seen_reg;
  logic rd_seen_next;
  logic wr_go;
  logic rd_go;
  byte_t      cfg_reg;
  byte_t      cfg_next;
  byte_t      thr_reg;
  byte_t      thr_next;
  byte_t      detect_period_reg;
  byte_t      detect_period_next;
  byte_t      clear_period_reg;
  byte_t      clear_period_next;
  byte_t      ram_addr_reg;
  byte_t      ram_addr_next;
  logic       rnw_reg;
  logic       rnw_next;
  byte_t      eq_cfg_reg;
  byte_t      eq_cfg_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [31:0] rword_reg;
  logic [31:0] rword_next;
  logic        loss_state_reg;
  logic        loss_state_next;
  logic        loss_chg_reg;
  logic        loss_chg_next;
  logic [11:0] det_cnt_reg;
  logic [11:0] det_cnt_next;
  logic [11:0] clr_cnt_reg;
  logic [11:0] clr_cnt_next;
  logic [5:0]  loc_reg;
  logic [5:0]  loc_next;
  logic [5:0]  ref_reg;
  logic [5:0]  ref_next;
  logic [5:0]  drift;
  logic [SW-1:0] settle_cnt_reg;
  logic [SW-1:0] settle_cnt_next;
  logic        settled_reg;
  logic        settled_next;
  ind_state_e  ind_reg;
  ind_state_e  ind_next;
  ram_req_s    req_reg;
  ram_req_s    req_next;
  logic [31:0] ram_rdata;
  byte_t       dout_reg;
  byte_t       dout_next;
  logic        oe_reg;
  logic        oe_next;
  logic        irq_n_reg;
  logic        irq_n_next;
  logic        rx_reg;
  logic        rx_next;
  logic        force_low_reg;
  logic        force_low_next;

  assign wr_go = !i_cs_n && !i_wr_n && !wr_seen_reg;
  assign rd_go = !i_cs_n && !i_rd_n && !rd_seen_reg;

  always_comb begin
    wr_seen_next = !i_cs_n && !i_wr_n;
    rd_seen_next = !i_cs_n && !i_rd_n;
    oe_next      = !i_cs_n && !i_rd_n && i_wr_n;
    dout_next    = dout_reg;
    if (rd_go) begin
      case (i_addr)
        `RL_OFS_CFG: begin
          dout_next = cfg_reg;
          dout_next[`RL_BIT_CHG]     = loss_chg_reg;
          dout_next[`RL_BIT_STATE]   = loss_state_reg;
          dout_next[`RL_BIT_SETTLED] = settled_reg;
        end
        `RL_OFS_THR:      dout_next = thr_reg;
        `RL_OFS_DETECT_PERIOD:  dout_next = detect_period_reg;
        `RL_OFS_CLEAR_PERIOD:  dout_next = clear_period_reg;
        `RL_OFS_RAM_ADDR: dout_next = ram_addr_reg;
        `RL_OFS_RNW:      dout_next = {rnw_reg, 7'h00};
        `RL_OFS_LOOP:     dout_next = {2'b00, loc_reg};
        `RL_OFS_EQ_CFG:   dout_next = eq_cfg_reg;
        `RL_OFS_DATA3:    dout_next = rword_reg[31:24];
        `RL_OFS_DATA2:    dout_next = rword_reg[23:16];
        `RL_OFS_DATA1:    dout_next = rword_reg[15:8];
        `RL_OFS_DATA0:    dout_next = rword_reg[7:0];
        default:          dout_next = 8'h00;
      endcase
    end
  end

  // Register writes and the indirect RAM sequencer.
  always_comb begin
    cfg_next      = cfg_reg;
    thr_next      = thr_reg;
    detect_period_next  = detect_period_reg;
    clear_period_next  = clear_period_reg;
    ram_addr_next = ram_addr_reg;
    rnw_next      = rnw_reg;
    eq_cfg_next   = eq_cfg_reg;
    wdata_next    = wdata_reg;
    rword_next    = rword_reg;
    ind_next      = ind_reg;
    req_next      = req_reg;
    case (ind_reg)
      IND_ACCESS: begin
        ind_next = req_reg.we ? IND_IDLE : IND_CAPTURE;
      end
      IND_CAPTURE: begin
        rword_next = ram_rdata;
        ind_next   = IND_IDLE;
      end
      default: begin
        ind_next = IND_IDLE;
      end
    endcase
    if (wr_go) begin
      case (i_addr)
        `RL_OFS_CFG:     cfg_next     = i_data & `RL_CFG_RW_MASK;
        `RL_OFS_THR:     thr_next     = i_data;
        `RL_OFS_DETECT_PERIOD: detect_period_next = i_data;
        `RL_OFS_CLEAR_PERIOD: clear_period_next = i_data;
        `RL_OFS_RAM_ADDR: begin
          ram_addr_next  = i_data;
          req_next.addr  = i_data;
          req_next.we    = !rnw_reg;
          req_next.wdata = wdata_reg;
          ind_next       = IND_ACCESS;
        end
        `RL_OFS_RNW:    rnw_next    = i_data[`RL_BIT_RNW];
        `RL_OFS_EQ_CFG: eq_cfg_next = i_data & `RL_EQ_CFG_MASK;
        `RL_OFS_DATA3:  wdata_next[31:24] = i_data;
        `RL_OFS_DATA2:  wdata_next[23:16] = i_data;
        `RL_OFS_DATA1:  wdata_next[15:8]  = i_data;
        `RL_OFS_DATA0:  wdata_next[7:0]   = i_data;
        default: begin
        end
      endcase
    end
  end

  // Loss-of-signal detection and clearance filter.
  always_comb begin
    loss_state_next = loss_state_reg;
    det_cnt_next    = det_cnt_reg;
    clr_cnt_next    = clr_cnt_reg;
    if (i_pulse_tick) begin
      if (!loss_state_reg) begin
        clr_cnt_next = '0;
        if (i_cable_loss_db >= thr_db(thr_reg[2:0])) begin
          if ({1'b0, det_cnt_reg} + 13'h0001 >= span(detect_period_reg)) begin
            loss_state_next = 1'b1;
            det_cnt_next    = '0;
          end else begin
            det_cnt_next = det_cnt_reg + 12'h001;
          end
        end else begin
          det_cnt_next = '0;
        end
      end else begin
        det_cnt_next = '0;
        if (i_cable_loss_db < thr_db(thr_reg[`RL_CLEAR_THRESHOLD_CODE_LSB +: 3])) begin
          if ({1'b0, clr_cnt_reg} + 13'h0001 >= span(clear_period_reg)) begin
            loss_state_next = 1'b0;
            clr_cnt_next    = '0;
          end else begin
            clr_cnt_next = clr_cnt_reg + 12'h001;
          end
        end else begin
          clr_cnt_next = '0;
        end
      end
    end
    // A change in the read cycle still leaves the flag set.
    loss_chg_next = loss_chg_reg;
    if (rd_go && i_addr == `RL_OFS_CFG) begin
      loss_chg_next = 1'b0;
    end
    if (loss_state_next != loss_state_reg) begin
      loss_chg_next = 1'b1;
    end
  end

  // Equalizer loop counter and settled detection.
  assign drift = (loc_reg > ref_reg) ? loc_reg - ref_reg : ref_reg - loc_reg;

  always_comb begin
    loc_next        = loc_reg;
    ref_next        = ref_reg;
    settle_cnt_next = settle_cnt_reg;
    settled_next    = settled_reg;
    if (eq_cfg_reg[`RL_BIT_EQ_RUN] && i_sample_tick) begin
      if (i_eq_up && !i_eq_down && loc_reg != 6'h3F) begin
        loc_next = loc_reg + 6'h01;
      end else if (i_eq_down && !i_eq_up && loc_reg != 6'h00) begin
        loc_next = loc_reg - 6'h01;
      end
      if (drift > `RL_SETTLE_STEPS) begin
        ref_next        = loc_reg;
        settle_cnt_next = '0;
        settled_next    = 1'b0;
      end else if (settle_cnt_reg == SW'(SETTLE_PERIODS)) begin
        settled_next = 1'b1;
      end else begin
        settle_cnt_next = settle_cnt_reg + SW'(1);
      end
    end
    if (wr_go && i_addr == `RL_OFS_LOOP) begin
      loc_next = i_data[5:0];
    end
  end

  always_comb begin
    irq_n_next     = !(loss_chg_next && cfg_next[`RL_BIT_IRQ_EN]);
    rx_next        = i_rx_data && !(cfg_reg[`RL_BIT_SQUELCH] && loss_state_reg);
    force_low_next = cfg_reg[`RL_BIT_QTEST] || i_global_quiescent_test;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_seen_reg    <= 1'b0;
      rd_seen_reg    <= 1'b0;
      cfg_reg        <= `RL_RST_CFG;
      thr_reg        <= `RL_RST_THR;
      detect_period_reg    <= `RL_RST_PER;
      clear_period_reg    <= `RL_RST_PER;
      ram_addr_reg   <= `RL_RST_RAM_ADDR;
      rnw_reg        <= `RL_RST_RNW;
      eq_cfg_reg     <= `RL_RST_EQ_CFG;
      wdata_reg      <= '0;
      rword_reg      <= '0;
      loss_state_reg <= 1'b0;
      loss_chg_reg   <= 1'b0;
      det_cnt_reg    <= '0;
      clr_cnt_reg    <= '0;
      loc_reg        <= `RL_RST_LOOP;
      ref_reg        <= `RL_RST_LOOP;
      settle_cnt_reg <= '0;
      settled_reg    <= 1'b0;
      ind_reg        <= IND_IDLE;
      req_reg        <= '0;
      dout_reg       <= 8'h00;
      oe_reg         <= 1'b0;
      irq_n_reg      <= 1'b1;
      rx_reg         <= 1'b0;
      force_low_reg  <= 1'b0;
    end else if (i_clk_en) begin
      wr_seen_reg    <= wr_seen_next;
      rd_seen_reg    <= rd_seen_next;
      cfg_reg        <= cfg_next;
      thr_reg        <= thr_next;
      detect_period_reg    <= detect_period_next;
      clear_period_reg    <= clear_period_next;
      ram_addr_reg   <= ram_addr_next;
      rnw_reg        <= rnw_next;
      eq_cfg_reg     <= eq_cfg_next;
      wdata_reg      <= wdata_next;
      rword_reg      <= rword_next;
      loss_state_reg <= loss_state_next;
      loss_chg_reg   <= loss_chg_next;
      det_cnt_reg    <= det_cnt_next;
      clr_cnt_reg    <= clr_cnt_next;
      loc_reg        <= loc_next;
      ref_reg        <= ref_next;
      settle_cnt_reg <= settle_cnt_next;
      settled_reg    <= settled_next;
      ind_reg        <= ind_next;
      req_reg        <= req_next;
      dout_reg       <= dout_next;
      oe_reg         <= oe_next;
      irq_n_reg      <= irq_n_next;
      rx_reg         <= rx_next;
      force_low_reg  <= force_low_next;
    end
  end

  eq_coeff_ram #(
    .DEPTH (256),
    .WIDTH (32),
    .LOC_W (6)
  ) u_ram (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_clk_en    (i_clk_en),
    .i_req_valid (ind_reg == IND_ACCESS),
    .i_req       (req_reg),
    .i_loc       (loc_reg),
    .o_rdata     (ram_rdata),
    .o_coeff     (o_eq_coeff)
  );

  assign o_data             = dout_reg;
  assign o_data_oe          = oe_reg;
  assign o_irq_n            = irq_n_reg;
  assign o_rx_data          = rx_reg;
  assign o_analog_force_low = force_low_reg;
  assign o_loss_state       = loss_state_reg;
  assign o_equalizer_run    = eq_cfg_reg[`RL_BIT_EQ_RUN];
endmodule

// ==== verification/rx_line_props.sv ====
// Concurrent checks on the ports of the receive line control block.
`timescale 1ns/1ps
module rx_line_props (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_cs_n,
  input wire logic       i_rd_n,
  input wire logic       i_wr_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic       o_data_oe,
  input wire logic       o_irq_n,
  input wire logic       i_pulse_tick,
  input wire logic [4:0] i_cable_loss_db,
  input wire logic       i_global_quiescent_test,
  input wire logic       i_rx_data,
  input wire logic       o_rx_data,
  input wire logic       o_analog_force_low,
  input wire logic       o_loss_state
);
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  cfg_q;
  logic [7:0]  thr_q;
  logic [7:0]  per_q;
  logic [11:0] run_q;
  wire         wr_s = !i_cs_n && !i_wr_n && !wr_q;
  wire         rd_s = !i_cs_n && !i_rd_n && !rd_q;
  function automatic logic [4:0] thr_db(input logic [2:0] c);
    return (c >= 3'h4) ? 5'h0C : 5'h08 + {2'h0, c};
  endfunction
  // Shadows of the control fields and a count of qualifying ticks since the last reset of the filter.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cfg_q <= 8'h01;
      thr_q <= 8'h00;
      per_q <= 8'h01;
      run_q <= 12'h000;
    end else begin
      wr_q <= !i_cs_n && !i_wr_n;
      rd_q <= !i_cs_n && !i_rd_n;
      if (wr_s && i_addr == 8'h70) cfg_q <= i_data;
      if (wr_s && i_addr == 8'h71) thr_q <= i_data;
      if (wr_s && i_addr == 8'h72) per_q <= i_data;
      if (o_loss_state) run_q <= 12'h000;
      else if (i_pulse_tick) run_q <= (i_cable_loss_db >= thr_db(thr_q[2:0])) ? run_q + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_IRQ_ON_CHANGE: assert property ($changed(o_loss_state) && cfg_q[5] |-> !o_irq_n)
    else $error("irq missing");
  AST_IRQ_MASKED: assert property (!cfg_q[5] && !$past(cfg_q[5]) |-> o_irq_n)
    else $error("irq while masked");
  AST_SQUELCH: assert property (cfg_q[4] && o_loss_state |=> !o_rx_data)
    else $error("data not squelched");
  AST_PASS: assert property (!cfg_q[4] |=> o_rx_data == $past(i_rx_data))
    else $error("data altered");
  AST_FORCE_LOW: assert property (o_analog_force_low == $past(i_global_quiescent_test || cfg_q[3]))
    else $error("force low wrong");
  AST_DETECT_LEVEL: assert property ($rose(o_loss_state) |-> $past(i_cable_loss_db) >= thr_db(thr_q[2:0]))
    else $error("detect level wrong");
  AST_CLEAR_LEVEL: assert property ($fell(o_loss_state) |-> $past(i_cable_loss_db) < thr_db(thr_q[6:4]))
    else $error("clear level wrong");
  AST_DETECT_COUNT: assert property ($rose(o_loss_state) && per_q != 8'h00 |-> run_q == {per_q, 4'h0})
    else $error("detect count wrong");
  AST_TICK_ONLY: assert property (!$past(i_pulse_tick) |-> $stable(o_loss_state))
    else $error("loss changed off tick");
  AST_READ_OE: assert property (rd_s |=> o_data_oe)
    else $error("read not driven");
  COV_RISE: cover property ($rose(o_loss_state));
  COV_FALL: cover property ($fell(o_loss_state));
  COV_IRQ: cover property ($fell(o_irq_n));
endmodule
bind rx_line_loss_monitor_eq_ctrl rx_line_props u_props (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr), .i_data(i_data), .o_data_oe(o_data_oe),
  .o_irq_n(o_irq_n), .i_pulse_tick(i_pulse_tick), .i_cable_loss_db(i_cable_loss_db),
  .i_global_quiescent_test(i_global_quiescent_test), .i_rx_data(i_rx_data), .o_rx_data(o_rx_data),
  .o_analog_force_low(o_analog_force_low), .o_loss_state(o_loss_state));

// ==== verification/rx_front_end_model.sv ====
// Behavioural analogue front end: line pulse ticks, sampling ticks and cable loss estimate.
`timescale 1ns/1ps
module rx_front_end_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_run,
  input  wire logic [4:0]  i_level,
  output logic             o_pulse_tick,
  output logic             o_sample_tick,
  output logic      [4:0]  o_cable_loss_db,
  output logic      [15:0] o_ticks
);
  logic [2:0] div_reg;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      div_reg <= 3'h0;
      o_ticks <= 16'h0000;
    end else if (!i_run) begin
      div_reg <= 3'h0;
      o_ticks <= 16'h0000;
    end else begin
      div_reg <= div_reg + 3'h1;
      o_ticks <= o_ticks + {15'h0, o_pulse_tick};
    end
  end
  // Outside a run the estimate is inverted so that a stale value never looks valid.
  assign o_pulse_tick    = i_run && (div_reg[1:0] == 2'h3);
  assign o_sample_tick   = i_run && (div_reg == 3'h7);
  assign o_cable_loss_db = i_run ? i_level : ~i_level;
endmodule

// ==== verification/tb_rx_line_loss_monitor_eq_ctrl.sv ====
// Self-checking bench for the receive line control block.
`timescale 1ns/1ps
module tb_rx_line_loss_monitor_eq_ctrl import rx_line_pkg::*;;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        wr_n = 1'b1;
  byte_t       addr = 8'h00;
  byte_t       wdata = 8'h00;
  logic        rx_in = 1'b0;
  logic        gtest = 1'b0;
  logic        eq_up = 1'b0;
  logic        eq_dn = 1'b0;
  logic        fe_run = 1'b0;
  logic [4:0]  fe_level = 5'h00;
  logic        p_tick, s_tick, irq_n, rx_out, force_low, loss, eq_run, oe;
  logic [4:0]  cable;
  logic [15:0] ticks;
  byte_t       dout;
  logic [31:0] coeff;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  byte_t       dflt [12] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};

  always #2.5 clk = ~clk;

  rx_line_loss_monitor_eq_ctrl #(.SETTLE_PERIODS(4)) DUT (.i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(dout), .o_data_oe(oe),
    .o_irq_n(irq_n), .i_pulse_tick(p_tick), .i_cable_loss_db(cable), .i_sample_tick(s_tick), .i_eq_up(eq_up),
    .i_eq_down(eq_dn), .i_global_quiescent_test(gtest), .i_rx_data(rx_in), .o_rx_data(rx_out),
    .o_analog_force_low(force_low), .o_loss_state(loss), .o_equalizer_run(eq_run), .o_eq_coeff(coeff));
  rx_front_end_model fe (.i_core_clk(clk), .i_reset(rst), .i_run(fe_run), .i_level(fe_level),
    .o_pulse_tick(p_tick), .o_sample_tick(s_tick), .o_cable_loss_db(cable), .o_ticks(ticks));

  task automatic summarize();
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits n edges and then steps off the edge, so that outputs are settled and inputs change clear of it.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
  endtask
  task automatic chkr(input byte_t a, input byte_t e);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (2) @(posedge clk);
    #1;
    cmp_val({24'h0, dout}, {24'h0, e});
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
  task automatic ind(input byte_t a, input logic [31:0] w, input logic rnw);
    if (!rnw) for (int i = 0; i < 4; i++) wr(8'h78 + 8'(i), w[31-8*i -: 8]);
    wr(8'h75, {rnw, 7'h00});
    wr(8'h74, a);
    repeat (3) @(posedge clk);
    if (rnw) for (int i = 0; i < 4; i++) chkr(8'h78 + 8'(i), w[31-8*i -: 8]);
  endtask
  task automatic restart(input logic [4:0] lvl);
    fe_run = 1'b0;
    fe_level = lvl;
    @(posedge clk);
    #1;
    fe_run = 1'b1;
  endtask
  task automatic wait_loss(input logic v);
    for (int i = 0; i < 2000 && loss !== v; i++) @(posedge clk) #1;
    cmp_bit(loss, v);
  endtask
  task automatic check_defaults();
    for (int i = 0; i < 12; i++) chkr(8'h70 + 8'(i), dflt[i]);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    check_defaults();
    wr(8'h7F, 8'hFF);
    chkr(8'h7F, 8'h00);
    wr(8'h70, 8'hFF);
    chkr(8'h70, 8'h39);
    wr(8'h71, 8'h73);
    chkr(8'h71, 8'h73);
    wr(8'h76, 8'hFF);
    chkr(8'h76, 8'h3F);
    wr(8'h70, 8'h09);
    step(2);
    cmp_bit(force_low, 1'b1);
    wr(8'h70, 8'h01);
    gtest = 1'b1;
    step(2);
    cmp_bit(force_low, 1'b1);
    gtest = 1'b0;
    step(2);
    cmp_bit(force_low, 1'b0);
    ind(8'h05, 32'hDEADBEEF, 1'b0);
    ind(8'h06, 32'h12345678, 1'b0);
    ind(8'h05, 32'hDEADBEEF, 1'b1);
    ind(8'h06, 32'h12345678, 1'b1);
    wr(8'h76, 8'h05);
    step(2);
    cmp_val(coeff, 32'hDEADBEEF);
    wr(8'h71, 8'h12);
    wr(8'h73, 8'h02);
    wr(8'h70, 8'h31);
    rx_in = 1'b1;
    restart(5'h09);
    step(160);
    cmp_bit(loss, 1'b0);
    restart(5'h0A);
    wait_loss(1'b1);
    cmp_val({16'h0, ticks}, 32'h10);
    cmp_bit(irq_n, 1'b0);
    @(posedge clk) #1;
    cmp_bit(rx_out, 1'b0);
    chkr(8'h70, 8'hF1);
    chkr(8'h70, 8'h71);
    cmp_bit(irq_n, 1'b1);
    restart(5'h09);
    step(160);
    cmp_bit(loss, 1'b1);
    restart(5'h08);
    wait_loss(1'b0);
    cmp_val({16'h0, ticks}, 32'h20);
    cmp_bit(irq_n, 1'b0);
    @(posedge clk) #1;
    cmp_bit(rx_out, 1'b1);
    chkr(8'h70, 8'hB1);
    eq_up = 1'b1;
    repeat (64) @(posedge clk);
    chkr(8'h76, 8'h05);
    wr(8'h77, 8'h0B);
    @(posedge clk) #1;
    cmp_bit(eq_run, 1'b1);
    wr(8'h76, 8'h3E);
    step(24);
    eq_up = 1'b0;
    chkr(8'h76, 8'h3F);
    repeat (80) @(posedge clk);
    chkr(8'h70, 8'h35);
    // Twenty-four edges hold exactly three sampling ticks, so the counter steps down by three.
    eq_dn = 1'b1;
    step(24);
    eq_dn = 1'b0;
    chkr(8'h76, 8'h3C);
    wr(8'h72, 8'h2D);
    wr(8'h73, 8'h2D);
    chkr(8'h72, 8'h2D);
    chkr(8'h73, 8'h2D);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    cmp_bit(loss, 1'b0);
    check_defaults();
    summarize();
  end
endmodule
